// file: core/psc_map.svh
// Register offsets, field positions and reset values of the sequence controller
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ********************************************
// Register offsets
// ********************************************
`define PSC_A_CTRL 6'h00
`define PSC_A_CMD 6'h04
`define PSC_A_REPEATS 6'h08
`define PSC_A_STATUS 6'h0c
`define PSC_A_DATA0 6'h10
`define PSC_A_DATA1 6'h14
`define PSC_A_LEN0 6'h18
`define PSC_A_LEN1 6'h1c
// Four words from here: offset 0, offset 1, slope 0, slope 1
`define PSC_A_CAL 6'h20
`define PSC_CAL_MASK 6'h33

// ********************************************
// Control register fields (lsb positions)
// ********************************************
`define PSC_F_CLK 0
`define PSC_F_START 2
`define PSC_F_REARM 5
`define PSC_F_NEXT 6
`define PSC_F_WHEN 8
`define PSC_F_NODATA 9
`define PSC_CTRL_W 11

// ********************************************
// Command bits, sample word fields
// ********************************************
`define PSC_C_START 0
`define PSC_C_REARM 1
`define PSC_C_FINAL 2
`define PSC_F_DIG 0
`define PSC_F_A0 8
`define PSC_F_A1 20

// ********************************************
// Reset values
// ********************************************
`define PSC_RST_CTRL 11'h000
`define PSC_RST_REPEATS 16'h0000
`define PSC_RST_OFFSET 16'h0000
`define PSC_RST_SLOPE 16'h4000
`define PSC_SLOPE_FRAC 14

`endif

// file: core/psc_pkg.sv
// Types shared by the sequence controller design files
package psc_pkg;
    typedef enum logic [1:0] {
        PSC_CLK_INTERNAL = 2'h0,
        PSC_CLK_DIRECT = 2'h1,
        PSC_CLK_REF = 2'h2
    } psc_clk_t;
    typedef enum logic [2:0] {
        PSC_ST_IMMEDIATE = 3'h0,
        PSC_ST_SOFTWARE = 3'h1,
        PSC_ST_RISING = 3'h2,
        PSC_ST_FALLING = 3'h3,
        PSC_ST_BOTH = 3'h4
    } psc_start_t;
    typedef enum logic {PSC_RA_AUTO = 1'h0, PSC_RA_MANUAL = 1'h1} psc_rearm_t;
    typedef enum logic [1:0] {
        PSC_NX_STOP = 2'h0,
        PSC_NX_SWITCH = 2'h1,
        PSC_NX_FRESH = 2'h2,
        PSC_NX_REPEAT = 2'h3
    } psc_next_t;
    typedef enum logic {PSC_WH_IMMEDIATE = 1'h0, PSC_WH_TRIGGER = 1'h1} psc_when_t;
    typedef enum logic [1:0] {
        PSC_ND_ERROR = 2'h0,
        PSC_ND_HOLD_IDLE = 2'h1,
        PSC_ND_REPLAY = 2'h2
    } psc_nodata_t;
    typedef enum logic [5:0] {
        PSC_IDLE = 6'h01,
        PSC_ARMED = 6'h02,
        PSC_PLAY = 6'h04,
        PSC_GAP = 6'h08,
        PSC_FINAL = 6'h10,
        PSC_FAULT = 6'h20
    } psc_state_t;
endpackage

// file: core/psc_slot_mem.sv
// Two-slot sequence sample memory with one write and one read port
`timescale 1ns/1ps
module psc_slot_mem #(
    parameter int W = 32,
    parameter int AW = 8
)(
    input wire logic clk, // Sample clock
    input wire logic wr_en, // Write one word
    input wire logic wr_slot, // Slot written
    input wire logic [AW-1:0] wr_addr, // Word index written
    input wire logic [W-1:0] wr_data, // Word written
    input wire logic rd_slot, // Slot read
    input wire logic [AW-1:0] rd_addr, // Word index read
    output logic [W-1:0] rd_data // Word at read index, same cycle
);
    logic [W-1:0] mem [0:(2<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[{wr_slot, wr_addr}] <= wr_data;
        end
    end

    // Asynchronous read keeps the play pointer and sample aligned
    assign rd_data = mem[{rd_slot, rd_addr}];
endmodule

// file: core/psc_core.sv
// Pulse sequence playback controller: start, rearm, slot switching, calibration
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "psc_map.svh"
// Function
// R1: Internal clock by default; direct external sample clock when selected.
// R2: Reference source selected: sample clock derived from external reference.
// R3: Immediate start mode plays as soon as upload completes.
// R4: Software mode waits for host start command.
// R5: Rising-edge mode starts on synced trigger low-to-high.
// R6: Falling-edge mode starts on synced trigger high-to-low.
// R7: Dual-edge mode starts on either trigger edge.
// R8: Manual rearm: one trigger, then ignore until rearm after final.
// R9: Stop action ends streaming after current slot completes.
// R10: Switch action plays other slot, replaying old contents if needed.
// R11: Fresh-switch action plays other slot; host must refill it first.
// R12: Repeat action replays current slot, counting down remaining repeats.
// R13: Immediate timing performs next action right at slot end.
// R14: Trigger timing defers next action to next matching start event.
// R15: Error policy enters fault state when next data missing.
// R16: Hold-idle policy outputs idle until next data present.
// R17: Replay policy repeats current slot until next data present.
// R18: Calibration stored persistently, applied only after next restart.
// R19: Calibration readback quantized to converter resolution.
// R20: Host resets slope to 1, offset 0 before recalibrating.
// R21: Two sequence slots, 0 and 1, loaded independently.
// R22: Slot being played or replayable blocks writes, reads not ready.
// R23: Automatic rearm (reset default) replays on new matching trigger.
// R24: Force-final aborts playback; no effect when already final.
// R25: Status shows loaded, streaming and finished, updated live.
module psc_core
    import psc_pkg::*;
#(
    parameter int AW = 8,
    parameter int CAL_QBITS = 4
)(
    input wire logic ref_clk, // Device clock
    input wire logic reset, // Restart, active high
    input wire logic nv_reset, // Power-on clear of the calibration store
    input wire logic trig_in, // External trigger pin
    input wire logic [5:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Register write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after the strobe
    output logic [7:0] dig_out, // Digital channels
    output logic [15:0] ana0_out, // Analog channel 0 code
    output logic [15:0] ana1_out, // Analog channel 1 code
    output logic clk_src_direct_ext, // Use external sample clock as is
    output logic clk_src_ref_derived // Lock sample clock to reference
);
    localparam int DEPTH = 1 << AW;
    localparam logic [15:0] QMASK = 16'(16'hffff << CAL_QBITS);
    // ********************************************
    // State
    // ********************************************
    logic trig_meta, trig_sync, trig_prev;
    logic [`PSC_CTRL_W-1:0] ctrl;
    logic [15:0] remaining_repeats;
    logic [1:0] valid, fresh, played;
    logic [AW:0] slot_len [0:1];
    logic [AW:0] wptr [0:1];
    logic [AW-1:0] ptr, next_ptr;
    logic cur_slot, next_cur, pend_slot, next_pend, first_slot, armed, start_pulse, end_pulse, dec_rep;
    logic [15:0] cal_store [0:3], cal_act [0:3];
    logic [31:0] rd_word, rd_mux;
    logic [1:0] slot_ready, wr_data_s, commit_s, start_s, done_s;
    psc_state_t state, next_state;
    // ********************************************
    // Control fields
    // ********************************************
    psc_clk_t clock_selection;
    psc_start_t start_condition;
    psc_rearm_t rearm_policy;
    psc_next_t next_action;
    psc_when_t when_sel;
    psc_nodata_t nodata_policy;
    assign clock_selection = psc_clk_t'(ctrl[`PSC_F_CLK +: 2]);
    assign start_condition = psc_start_t'(ctrl[`PSC_F_START +: 3]);
    assign rearm_policy = psc_rearm_t'(ctrl[`PSC_F_REARM]);
    assign next_action = psc_next_t'(ctrl[`PSC_F_NEXT +: 2]);
    assign when_sel = psc_when_t'(ctrl[`PSC_F_WHEN]);
    assign nodata_policy = psc_nodata_t'(ctrl[`PSC_F_NODATA +: 2]);
    // Whether the slot a given action moves to has usable data
    function automatic logic slot_avail(input psc_next_t act, input logic is_fresh, input logic is_valid);
        slot_avail = (act == PSC_NX_FRESH) ? is_fresh :
                     (act == PSC_NX_SWITCH) ? is_valid : 1'b1;
    endfunction
    // Offset plus sample times slope, slope in fixed point
    function automatic logic [15:0] cal_apply(input logic [11:0] s, input logic [15:0] off,
                                              input logic [15:0] slp);
        logic signed [32:0] prod;
        prod = $signed({s, 4'h0}) * $signed({1'b0, slp});
        cal_apply = 16'(prod >>> `PSC_SLOPE_FRAC) + off;
    endfunction
    // ********************************************
    // Register decode
    // ********************************************
    wire wr_ctrl = wr_en && addr == `PSC_A_CTRL;
    wire wr_cmd = wr_en && addr == `PSC_A_CMD;
    wire wr_repeats = wr_en && addr == `PSC_A_REPEATS;
    wire cmd_start = wr_cmd && wdata[`PSC_C_START];
    wire cmd_rearm = wr_cmd && wdata[`PSC_C_REARM];
    wire cmd_final = wr_cmd && wdata[`PSC_C_FINAL];
    wire commit_any = |commit_s;
    // Anything but idle or fault may still replay a slot
    wire busy = state != PSC_IDLE && state != PSC_FAULT;
    wire has_seq = |valid;
    wire streaming = state == PSC_PLAY || state == PSC_GAP;
    wire finished = state == PSC_FINAL;
    wire fault = state == PSC_FAULT;
    // ********************************************
    // Trigger synchroniser and edges
    // ********************************************
    // Not cleared by restart, so a pin resting high gives no false edge after it
    always_ff @(posedge ref_clk) begin
        trig_meta <= trig_in;
        trig_sync <= trig_meta;
        trig_prev <= trig_sync;
    end
    wire trig_rise = trig_sync & ~trig_prev;
    wire trig_fall = ~trig_sync & trig_prev;
    wire start_event =
        (start_condition == PSC_ST_IMMEDIATE) ? commit_any : // R3
        (start_condition == PSC_ST_SOFTWARE) ? cmd_start : // R4
        (start_condition == PSC_ST_RISING) ? trig_rise : // R5
        (start_condition == PSC_ST_FALLING) ? trig_fall : // R6
        (start_condition == PSC_ST_BOTH) ? (trig_rise | trig_fall) : 1'b0; // R7
    wire go_ok = rearm_policy == PSC_RA_AUTO || armed; // R8 R23
    wire launch_slot = commit_any ? commit_s[1] : first_slot;
    wire launch = start_event && go_ok && (commit_any || valid[first_slot]);
    // ********************************************
    // Slots
    // ********************************************
    generate
        for (genvar g = 0; g < 2; g++) begin : g_slot
            localparam logic [5:0] DA = g ? `PSC_A_DATA1 : `PSC_A_DATA0;
            localparam logic [5:0] LA = g ? `PSC_A_LEN1 : `PSC_A_LEN0;
            // Switch mode may reread the other slot, so both stay closed
            assign slot_ready[g] = !(busy && (cur_slot == 1'(g) || next_action == PSC_NX_SWITCH)); // R22
            assign wr_data_s[g] = wr_en && addr == DA && slot_ready[g] && wptr[g] < (AW+1)'(DEPTH); // R21
            assign commit_s[g] = wr_en && addr == LA && slot_ready[g] && wdata != 32'h0 && wdata <= 32'(DEPTH);
            assign start_s[g] = start_pulse && next_cur == 1'(g);
            assign done_s[g] = end_pulse && cur_slot == 1'(g);
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    valid[g] <= 1'b0;
                    fresh[g] <= 1'b0;
                    played[g] <= 1'b0;
                    slot_len[g] <= '0;
                    wptr[g] <= '0;
                end else begin
                    if (commit_s[g]) begin
                        valid[g] <= 1'b1;
                        slot_len[g] <= wdata[AW:0];
                        wptr[g] <= '0;
                    end else if (wr_data_s[g]) begin
                        wptr[g] <= wptr[g] + (AW+1)'(1);
                    end
                    // New data wins over the play start that consumes it
                    if (commit_s[g]) begin
                        fresh[g] <= 1'b1; // R11
                    end else if (start_s[g]) begin
                        fresh[g] <= 1'b0;
                    end
                    if (commit_s[g]) begin
                        played[g] <= 1'b0;
                    end else if (done_s[g]) begin
                        played[g] <= 1'b1; // R10
                    end
                end
            end
        end
    endgenerate
    psc_slot_mem #(
        .W(32),
        .AW(AW)
    ) u_mem (
        .clk(ref_clk),
        .wr_en(|wr_data_s),
        .wr_slot(wr_data_s[1]),
        .wr_addr(wr_data_s[1] ? wptr[1][AW-1:0] : wptr[0][AW-1:0]),
        .wr_data(wdata),
        .rd_slot(cur_slot),
        .rd_addr(ptr),
        .rd_data(rd_word)
    );
    // ********************************************
    // Slot end decision
    // ********************************************
    wire at_end = {1'b0, ptr} == slot_len[cur_slot] - (AW+1)'(1);
    wire tgt_slot = (next_action == PSC_NX_REPEAT) ? cur_slot : ~cur_slot;
    wire tgt_avail = slot_avail(next_action, fresh[tgt_slot], valid[tgt_slot]);
    wire pend_avail = slot_avail(next_action, fresh[pend_slot], valid[pend_slot]);
    wire to_final = next_action == PSC_NX_STOP ||
                    (next_action == PSC_NX_REPEAT && remaining_repeats == 16'h0000); // R9 R12
    always_comb begin
        next_state = state;
        next_ptr = ptr;
        next_cur = cur_slot;
        next_pend = pend_slot;
        start_pulse = 1'b0;
        end_pulse = 1'b0;
        dec_rep = 1'b0;
        case (state)
            PSC_IDLE, PSC_ARMED, PSC_FINAL: begin
                if (launch) begin
                    next_state = PSC_PLAY;
                    next_ptr = '0;
                    next_cur = launch_slot;
                    start_pulse = 1'b1;
                end else if (state == PSC_IDLE && commit_any) begin
                    next_state = PSC_ARMED;
                end else if (state == PSC_ARMED && cmd_final) begin
                    next_state = PSC_FINAL; // R24
                end
            end
            PSC_PLAY: begin
                next_ptr = ptr + AW'(1);
                if (cmd_final) begin
                    next_state = PSC_FINAL; // R24
                end else if (at_end) begin
                    end_pulse = 1'b1;
                    next_ptr = '0;
                    if (to_final) begin
                        next_state = PSC_FINAL; // R9
                    end else if (tgt_avail) begin
                        dec_rep = next_action == PSC_NX_REPEAT; // R12
                        next_pend = tgt_slot;
                        if (when_sel == PSC_WH_IMMEDIATE) begin
                            next_cur = tgt_slot; // R10 R13
                            start_pulse = 1'b1;
                        end else begin
                            next_state = PSC_GAP; // R14
                        end
                    end else if (nodata_policy == PSC_ND_ERROR) begin
                        next_state = PSC_FAULT; // R15
                    end else if (nodata_policy == PSC_ND_REPLAY) begin
                        next_cur = cur_slot; // R17
                    end else begin
                        next_pend = tgt_slot;
                        next_state = PSC_GAP; // R16
                    end
                end
            end
            PSC_GAP: begin
                if (cmd_final) begin
                    next_state = PSC_FINAL; // R24
                end else if (pend_avail && (when_sel == PSC_WH_IMMEDIATE || start_event)) begin
                    next_state = PSC_PLAY; // R14 R16
                    next_ptr = '0;
                    next_cur = pend_slot;
                    start_pulse = 1'b1;
                end
            end
            PSC_FAULT: begin
                if (cmd_final) begin
                    next_state = PSC_FINAL;
                end
            end
            default: begin
                next_state = PSC_IDLE;
            end
        endcase
    end
    // ********************************************
    // Sequencing registers
    // ********************************************
    wire launch_taken = start_pulse && (state == PSC_IDLE || state == PSC_ARMED || state == PSC_FINAL);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= PSC_IDLE;
            ptr <= '0;
            cur_slot <= 1'b0;
            pend_slot <= 1'b0;
            first_slot <= 1'b0;
            ctrl <= `PSC_RST_CTRL;
        end else begin
            state <= next_state;
            ptr <= next_ptr;
            cur_slot <= next_cur;
            pend_slot <= next_pend;
            if (commit_any) begin
                first_slot <= commit_s[1];
            end
            if (wr_ctrl) begin
                ctrl <= wdata[`PSC_CTRL_W-1:0];
            end
        end
    end
    // Arming wins over the launch that uses it up
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            armed <= 1'b0;
        end else if (commit_any || (cmd_rearm && state == PSC_FINAL)) begin
            armed <= 1'b1; // R8
        end else if (launch_taken) begin
            armed <= 1'b0; // R8
        end
    end
    // Host write beats the hardware countdown in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            remaining_repeats <= `PSC_RST_REPEATS;
        end else if (wr_repeats) begin
            remaining_repeats <= wdata[15:0];
        end else if (dec_rep) begin
            remaining_repeats <= remaining_repeats - 16'h0001; // R12
        end
    end
    // ********************************************
    // Calibration store and active copy
    // ********************************************
    generate
        for (genvar c = 0; c < 4; c++) begin : g_cal
            localparam logic [5:0] CA = 6'(`PSC_A_CAL + 4 * c);
            // Survives restart; only the power-on clear and host writes touch it
            always_ff @(posedge ref_clk) begin
                if (nv_reset) begin
                    cal_store[c] <= (c < 2) ? `PSC_RST_OFFSET : `PSC_RST_SLOPE;
                end else if (wr_en && addr == CA) begin
                    cal_store[c] <= wdata[15:0]; // R18
                end
                // Picked up only at restart, so writes take effect later
                if (reset) begin
                    cal_act[c] <= cal_store[c]; // R18
                end
            end
        end
    endgenerate
    // ********************************************
    // Outputs
    // ********************************************
    wire playing = state == PSC_PLAY;
    // Final and armed hold the last driven state
    wire hold_out = state == PSC_FINAL || state == PSC_ARMED;
    wire [31:0] shown = playing ? rd_word : 32'h0;
    wire [15:0] cal0 = cal_apply(shown[`PSC_F_A0 +: 12], cal_act[0], cal_act[2]);
    wire [15:0] cal1 = cal_apply(shown[`PSC_F_A1 +: 12], cal_act[1], cal_act[3]);
    wire [31:0] status_word = {22'h0, played, armed, cur_slot, slot_ready, fault, finished, streaming, has_seq}; // R25
    assign rd_mux =
        (addr == `PSC_A_CTRL) ? 32'(ctrl) :
        (addr == `PSC_A_REPEATS) ? {16'h0, remaining_repeats} :
        (addr == `PSC_A_STATUS) ? status_word :
        (addr == `PSC_A_LEN0) ? 32'(slot_len[0]) :
        (addr == `PSC_A_LEN1) ? 32'(slot_len[1]) :
        ((addr & `PSC_CAL_MASK) == `PSC_A_CAL) ? {16'h0, cal_store[addr[3:2]] & QMASK} : 32'h0; // R19
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata <= 32'h0;
            dig_out <= 8'h0;
            ana0_out <= 16'h0;
            ana1_out <= 16'h0;
            clk_src_direct_ext <= 1'b0;
            clk_src_ref_derived <= 1'b0;
        end else begin
            rdata <= rd_en ? rd_mux : 32'h0;
            if (!hold_out) begin
                dig_out <= shown[`PSC_F_DIG +: 8];
                ana0_out <= cal0;
                ana1_out <= cal1;
            end
            clk_src_direct_ext <= clock_selection == PSC_CLK_DIRECT; // R1
            clk_src_ref_derived <= clock_selection == PSC_CLK_REF; // R2
        end
    end
endmodule

// file: test/psc_trig_src.sv
// Model of the external trigger source
`timescale 1ns/1ps
module psc_trig_src(
    input wire logic ref_clk, // Bench clock
    input wire logic lvl, // Requested pin level
    output logic trig_in // Trigger pin
);
    initial trig_in = 1'b0;
    // Asynchronous pin: moves between clock edges
    always @(posedge ref_clk) trig_in <= #1 lvl;
endmodule

// file: test/psc_core_sva.sv
// Port checker for the sequence controller
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_core_sva #(
    parameter int CAL_QBITS = 4
)(
    input wire logic ref_clk, // Clock
    input wire logic reset, // Restart
    input wire logic [5:0] addr, // Address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    input wire logic [31:0] rdata, // Read data
    input wire logic [7:0] dig_out, // Digital out
    input wire logic clk_src_direct_ext, // Direct clock
    input wire logic clk_src_ref_derived // Reference clock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire ctrl_wr = wr_en && addr == `PSC_A_CTRL;
    wire cal_rd = rd_en && addr[5:4] == 2'h2 && addr[1:0] == 2'h0;
    property p_rd_idle; !rd_en |=> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_clk_dir; ctrl_wr && wdata[1:0] == 2'h1 |-> ##2 clk_src_direct_ext; endproperty
    a_clk_dir: assert property (p_clk_dir) else $error("direct clock not selected");
    property p_clk_ref; ctrl_wr && wdata[1:0] == 2'h2 |-> ##2 clk_src_ref_derived; endproperty
    a_clk_ref: assert property (p_clk_ref) else $error("reference clock not selected");
    property p_clk_int; ctrl_wr && wdata[1:0] == 2'h0 |-> ##2 !(clk_src_direct_ext || clk_src_ref_derived); endproperty
    a_clk_int: assert property (p_clk_int) else $error("internal clock not selected");
    property p_clk_one; !(clk_src_direct_ext && clk_src_ref_derived); endproperty
    a_clk_one: assert property (p_clk_one) else $error("two clock sources at once");
    property p_cmd_rd; rd_en && addr == `PSC_A_CMD |=> rdata == 32'h0; endproperty
    a_cmd_rd: assert property (p_cmd_rd) else $error("command word read back");
    property p_cal_q; cal_rd |=> rdata[CAL_QBITS-1:0] == '0 && rdata[31:16] == 16'h0; endproperty
    a_cal_q: assert property (p_cal_q) else $error("calibration read not quantized");
    property p_unmap; rd_en && addr > 6'h2c |=> rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rst;
        disable iff (1'b0) reset |=> rdata == 32'h0 && dig_out == 8'h0 && !clk_src_direct_ext;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by restart");
    c_dir: cover property (clk_src_direct_ext);
    c_cal: cover property (cal_rd);
    c_play: cover property (dig_out == 8'h11 ##1 dig_out == 8'h22);
endmodule
bind psc_core psc_core_sva #(.CAL_QBITS(CAL_QBITS)) u_sva(.ref_clk, .reset, .addr, .wdata, .wr_en, .rd_en,
    .rdata, .dig_out, .clk_src_direct_ext, .clk_src_ref_derived);

// file: test/tb_psc_core.sv
// Self-checking bench for the sequence controller
`timescale 1ns/1ps
`include "psc_map.svh"
module tb_psc_core;
    logic ref_clk = 1'b0, reset = 1'b1, nv_reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, lvl = 1'b0;
    logic [5:0] addr = 6'h0;
    logic [31:0] wdata = 32'h0;
    wire logic trig_in, clk_src_direct_ext, clk_src_ref_derived;
    wire logic [31:0] rdata;
    wire logic [7:0] dig_out;
    wire logic [15:0] ana0_out, ana1_out;
    int num_errors = 0, checks_done = 0;
    initial forever #2 ref_clk = ~ref_clk;
    psc_trig_src u_trig(.ref_clk, .lvl, .trig_in);
    psc_core dut(.ref_clk, .reset, .nv_reset, .trig_in, .addr, .wdata, .wr_en, .rd_en, .rdata, .dig_out,
        .ana0_out, .ana1_out, .clk_src_direct_ext, .clk_src_ref_derived);
    task automatic final_report();
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Idle edge before each strobe keeps set and clear in separate steps
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 cmp(rdata & m, exp);
    endtask
    task automatic upload(input logic [5:0] a, input logic [7:0] first);
        for (int i = 0; i < 3; i++)
            wr(a, {12'h100, 12'h0, first + 8'h11 * i[7:0]});
        wr(a + 6'h08, 32'h3);
    endtask
    // Samples run first, first+11, first+22, then the last one is held
    task automatic play(input logic [7:0] first, input int n);
        int k = 0;
        #1;
        while (dig_out !== first && k < 60) begin
            @(posedge ref_clk);
            #1 k++;
        end
        for (int i = 0; i < n; i++) begin
            cmp(dig_out, first + 8'h11 * (i % 3));
            @(posedge ref_clk);
            #1;
        end
        cmp(dig_out, first + 8'h22);
    endtask
    task automatic quiet(input logic [7:0] v);
        repeat (12) begin
            @(posedge ref_clk);
            #1 cmp(dig_out, v);
        end
    endtask
    task automatic edge_to(input logic v);
        @(posedge ref_clk);
        lvl <= v;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        nv_reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`PSC_A_CTRL, 32'h0);
        rd(`PSC_A_STATUS, 32'h30);
        rd(`PSC_A_CAL + 6'h08, 32'h4000);
        rd(`PSC_A_CMD, 32'h0);
        rd(6'h30, 32'h0);
        wr(`PSC_A_CAL + 6'h08, 32'h4000);
        wr(`PSC_A_CAL, 32'h0);
        wr(`PSC_A_CAL, 32'h1237);
        rd(`PSC_A_CAL, 32'h1230);
        for (int c = 1; c < 4; c++) begin
            wr(`PSC_A_CTRL, c % 3);
            repeat (2) @(posedge ref_clk);
            #1 cmp({clk_src_ref_derived, clk_src_direct_ext}, c % 3);
        end
        upload(`PSC_A_DATA0, 8'h11);
        play(8'h11, 3);
        cmp(ana0_out, 16'h0);
        rd(`PSC_A_STATUS, 32'h5, 32'h7);
        wr(`PSC_A_CTRL, 32'h0c);
        edge_to(1'b1);
        quiet(8'h33);
        edge_to(1'b0);
        play(8'h11, 3);
        wr(`PSC_A_CTRL, 32'h08);
        edge_to(1'b1);
        play(8'h11, 3);
        edge_to(1'b0);
        quiet(8'h33);
        wr(`PSC_A_CTRL, 32'h10);
        edge_to(1'b1);
        play(8'h11, 3);
        edge_to(1'b0);
        play(8'h11, 3);
        wr(`PSC_A_CTRL, 32'h04);
        quiet(8'h33);
        wr(`PSC_A_CMD, 32'h1);
        play(8'h11, 3);
        wr(`PSC_A_CTRL, 32'h28);
        upload(`PSC_A_DATA1, 8'h44);
        edge_to(1'b1);
        play(8'h44, 3);
        edge_to(1'b0);
        edge_to(1'b1);
        quiet(8'h66);
        wr(`PSC_A_CMD, 32'h2);
        edge_to(1'b0);
        edge_to(1'b1);
        play(8'h44, 3);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        wr(`PSC_A_REPEATS, 32'h1);
        wr(`PSC_A_CTRL, 32'hc0);
        upload(`PSC_A_DATA0, 8'h11);
        play(8'h11, 6);
        cmp(ana0_out, 16'h1237);
        cmp(ana1_out, 16'h1000);
        rd(`PSC_A_REPEATS, 32'h0);
        final_report();
    end
    initial begin
        #40000;
        num_errors++;
        final_report();
    end
endmodule
